// *** hdl/vco_band_automatic_band_calibration_controller.sv ***
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - calibration picks the capacitor sub-band on each integer write in integer mode, or on each fractional write in fractional mode, unless disabled
// - host may write vco switch settings directly through the forwarding register
// - other vco control bits travel through the same forwarding register
// - calibration holds tuning at mid-point and searches the closest switch setting
// - with calibration enabled, one calibration run per frequency change
// - calibration switch frames keep the forwarding register subsystem address
// - auto-relock set and lock lost: rerun calibration to relock
// - relock attempted only once per lock failure
// - selected switch setting readable in 8-bit read-back after each calibration
// - manual switch writes take effect immediately
// - calibration disabled: integer and fractional writes load immediately
// - calibration disabled: each forwarded value updates the vco at once, except an illegal divider ratio, which leaves the ratio unchanged
// - each forwarded transfer takes 16 link clock cycles
// - vco modes: fundamental, divide by 1 or even up to 62, doubler
// - two-bit output gain field in vco divider register
// - fractional mode: fractional write starts calibration, loads after it ends
// - calibration clock is reference divided by 2^m, m in 0,2,4,5
// - rewriting the same frequency reruns calibration, same final frequency
module vco_band_automatic_band_calibration_controller (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   // register port
   input  wire logic [4:0]  i_addr,
   input  wire logic [23:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [23:0] o_rdata,
   // analog loop
   input  wire logic        i_lock_detect,
   input  wire logic        i_vco_edge,
   output logic             o_vtune_hold,
   output logic      [18:0] o_int_active,
   output logic      [23:0] o_frac_active,
   output logic             o_cal_busy,
   // vco subsystem
   output logic             o_vco_link_clock,
   output logic             o_vco_link_data,
   output logic             o_vco_link_sel_b,
   output logic      [5:0]  o_out_div_ratio,
   output logic      [1:0]  o_out_gain,
   output logic             o_doubler_en
);

   // register file
   logic [23:0] ref_div_q, int_q, frac_q, fwd_q, mode_q, lock_cfg_q, cal_cfg_q;
   logic [7:0]  switch_q;
   logic [23:0] rdata_d;

   // decode
   logic wr_ref, wr_int, wr_frac, wr_fwd, wr_mode, wr_lock, wr_cal;
   assign wr_ref  = i_wr && (i_addr == vco_cal_pkg::REG_REF_DIV);
   assign wr_int  = i_wr && (i_addr == vco_cal_pkg::REG_INT);
   assign wr_frac = i_wr && (i_addr == vco_cal_pkg::REG_FRAC);
   assign wr_fwd  = i_wr && (i_addr == vco_cal_pkg::REG_FWD);
   assign wr_mode = i_wr && (i_addr == vco_cal_pkg::REG_MODE);
   assign wr_lock = i_wr && (i_addr == vco_cal_pkg::REG_LOCK_CFG);
   assign wr_cal  = i_wr && (i_addr == vco_cal_pkg::REG_CAL_CFG);

   // configuration fields
   logic       frac_mode, cal_dis, relock_en;
   logic [2:0] cal_n;
   logic [1:0] cal_k, cal_m;
   assign frac_mode = mode_q[vco_cal_pkg::MODE_FRAC_BIT];
   assign cal_dis   = cal_cfg_q[vco_cal_pkg::CAL_DIS_BIT];
   assign relock_en = lock_cfg_q[vco_cal_pkg::LOCK_RELOCK_BIT];
   assign cal_n     = cal_cfg_q[vco_cal_pkg::CAL_N_LSB +: 3];
   assign cal_k     = cal_cfg_q[vco_cal_pkg::CAL_K_LSB +: 2];
   assign cal_m     = cal_cfg_q[vco_cal_pkg::CAL_M_LSB +: 2];

   // calibration state
   vco_cal_pkg::cal_state_e state_q, state_d;
   logic [7:0]  sel_q, trial;
   logic [2:0]  bit_idx_q;
   logic [9:0]  wait_q;
   logic [31:0] win_q, meas_q;
   logic        cal_pend_q, cal_req_q;
   logic        host_pend_q;
   logic [15:0] host_word_q, fly_word_q;
   logic        fly_cal_q;
   logic        lock_s1_q, lock_s2_q, armed_q;
   logic [4:0]  div_cnt_q;

   // fsm clock tick, reference divided by 2^m
   logic [4:0] tick_mask;
   logic       tick;
   assign tick_mask = (cal_m == 2'h0) ? 5'h00 :
                      (cal_m == 2'h1) ? 5'h03 :
                      (cal_m == 2'h2) ? 5'h0f : 5'h1f;
   assign tick = ((div_cnt_q & tick_mask) == tick_mask);

   // frequency write triggers
   logic freq_trig, relock_fire, cal_start;
   assign freq_trig = !cal_dis && ((wr_frac && frac_mode)
                                || (wr_int && !frac_mode));
   assign relock_fire = relock_en && !cal_dis && armed_q && !lock_s2_q
                        && (state_q == vco_cal_pkg::CAL_IDLE) && !cal_pend_q;
   assign cal_start = cal_pend_q && (state_q == vco_cal_pkg::CAL_IDLE);

   // expected vco count over the window: floor(N * 2^n)
   logic [49:0] n_full;
   logic [31:0] expect_cnt, win_len;
   assign n_full     = {7'h00, int_q[vco_cal_pkg::INT_W-1:0], frac_q} << cal_n;
   assign expect_cnt = 32'(n_full >> 24);
   assign win_len    = {8'h00, ref_div_q} << cal_n;

   // search trial and link frames
   logic [15:0] cal_word, link_word;
   logic        link_busy, link_done, link_start, send_host;
   assign trial    = sel_q | (8'h01 << bit_idx_q);
   assign cal_word = {1'b0, ((state_q == vco_cal_pkg::CAL_FINAL) ? sel_q : trial),
                      vco_cal_pkg::VREG_SWITCH,
                      fwd_q[vco_cal_pkg::FWD_ID_LSB +: 3]};
   assign send_host  = host_pend_q && !link_busy;
   assign link_start = !link_busy && (host_pend_q || cal_req_q);
   assign link_word  = host_pend_q ? host_word_q : cal_word;

   // frame arriving at the vco
   logic [3:0] fly_reg;
   logic [8:0] fly_data;
   logic       div_legal;
   assign fly_reg   = fly_word_q[vco_cal_pkg::FWD_REG_LSB +: 4];
   assign fly_data  = fly_word_q[vco_cal_pkg::FWD_DATA_LSB +: 9];
   assign div_legal = (fly_data[5:0] == 6'h01)
                   || (!fly_data[0] && fly_data[5:0] != 6'h00
                       && fly_data[5:0] <= vco_cal_pkg::DIV_MAX);

   // read mux
   assign rdata_d = !i_rd ? 24'h00_0000 :
      (i_addr == vco_cal_pkg::REG_REF_DIV)  ? ref_div_q :
      (i_addr == vco_cal_pkg::REG_INT)      ? int_q :
      (i_addr == vco_cal_pkg::REG_FRAC)     ? frac_q :
      (i_addr == vco_cal_pkg::REG_FWD)      ? fwd_q :
      (i_addr == vco_cal_pkg::REG_MODE)     ? mode_q :
      (i_addr == vco_cal_pkg::REG_LOCK_CFG) ? lock_cfg_q :
      (i_addr == vco_cal_pkg::REG_CAL_CFG)  ? cal_cfg_q :
      (i_addr == vco_cal_pkg::REG_READBACK) ?
         {14'h0000, lock_s2_q, o_cal_busy, switch_q} : 24'h00_0000;

   // calibration sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         vco_cal_pkg::CAL_IDLE: begin
            if (cal_start) begin
               state_d = vco_cal_pkg::CAL_SEND;
            end
         end
         vco_cal_pkg::CAL_SEND: begin
            if (link_done && fly_cal_q) begin
               state_d = vco_cal_pkg::CAL_WAIT;
            end
         end
         vco_cal_pkg::CAL_WAIT: begin
            if (wait_q == 10'h000) begin
               state_d = vco_cal_pkg::CAL_MEASURE;
            end
         end
         vco_cal_pkg::CAL_MEASURE: begin
            if (win_q <= 32'h0000_0001) begin
               state_d = vco_cal_pkg::CAL_DECIDE;
            end
         end
         vco_cal_pkg::CAL_DECIDE: begin
            state_d = (bit_idx_q == 3'h0) ? vco_cal_pkg::CAL_FINAL : vco_cal_pkg::CAL_SEND;
         end
         vco_cal_pkg::CAL_FINAL: begin
            if (link_done && fly_cal_q) begin
               state_d = vco_cal_pkg::CAL_LOAD;
            end
         end
         vco_cal_pkg::CAL_LOAD: begin
            state_d = vco_cal_pkg::CAL_IDLE;
         end
         default: begin
            state_d = vco_cal_pkg::CAL_IDLE;
         end
      endcase
   end

   // host registers
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ref_div_q  <= vco_cal_pkg::RST_REF_DIV;
         int_q      <= vco_cal_pkg::RST_INT;
         frac_q     <= vco_cal_pkg::RST_FRAC;
         fwd_q      <= vco_cal_pkg::RST_FWD;
         mode_q     <= vco_cal_pkg::RST_MODE;
         lock_cfg_q <= vco_cal_pkg::RST_LOCK_CFG;
         cal_cfg_q  <= vco_cal_pkg::RST_CAL_CFG;
         o_rdata    <= 24'h00_0000;
      end else begin
         if (wr_ref)  ref_div_q  <= i_wdata;
         if (wr_int)  int_q      <= i_wdata;
         if (wr_frac) frac_q     <= i_wdata;
         if (wr_fwd)  fwd_q      <= i_wdata;
         if (wr_mode) mode_q     <= i_wdata;
         if (wr_lock) lock_cfg_q <= i_wdata;
         if (wr_cal)  cal_cfg_q  <= i_wdata;
         o_rdata <= rdata_d;
      end
   end

   // active frequency words toward prescaler and modulator
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_int_active  <= 19'h0_0000;
         o_frac_active <= 24'h00_0000;
      end else if (state_q == vco_cal_pkg::CAL_LOAD) begin
         o_int_active  <= int_q[vco_cal_pkg::INT_W-1:0];
         o_frac_active <= frac_q;
      end else if (cal_dis) begin
         if (wr_int)  o_int_active  <= i_wdata[vco_cal_pkg::INT_W-1:0];
         if (wr_frac) o_frac_active <= i_wdata;
      end
   end

   // forwarding queue; a host frame takes the link ahead of a search frame
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         host_pend_q <= 1'b0;
         host_word_q <= 16'h0000;
         fly_word_q  <= 16'h0000;
         fly_cal_q   <= 1'b0;
         div_cnt_q   <= 5'h00;
      end else begin
         div_cnt_q <= div_cnt_q + 5'h01;
         if (wr_fwd) begin
            host_pend_q <= 1'b1;
            host_word_q <= i_wdata[15:0];
         end else if (send_host) begin
            host_pend_q <= 1'b0;
         end
         if (link_start) begin
            fly_word_q <= link_word;
            fly_cal_q  <= !host_pend_q;
         end
      end
   end

   // vco subsystem shadow, updated when a host frame completes; the switch copy is also loaded from the search at calibration load
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         switch_q        <= 8'h00;
         o_out_div_ratio <= vco_cal_pkg::RST_DIV;
         o_out_gain      <= 2'h0;
         o_doubler_en    <= 1'b0;
      end else if (link_done) begin
         if (fly_reg == vco_cal_pkg::VREG_SWITCH && !fly_cal_q) begin
            switch_q <= fly_data[7:0];
         end
         if (fly_reg == vco_cal_pkg::VREG_DIV) begin
            if (div_legal) begin
               o_out_div_ratio <= fly_data[5:0];
            end
            o_out_gain <= fly_data[vco_cal_pkg::DIV_GAIN_LSB +: 2];
         end
         if (fly_reg == vco_cal_pkg::VREG_CFG) begin
            o_doubler_en <= fly_data[0];
         end
      end else if (state_q == vco_cal_pkg::CAL_LOAD) begin
         switch_q <= sel_q;
      end
   end

   // lock detect synchroniser and single relock arming
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lock_s1_q <= 1'b0;
         lock_s2_q <= 1'b0;
         armed_q   <= 1'b0;
      end else begin
         lock_s1_q <= i_lock_detect;
         lock_s2_q <= lock_s1_q;
         if (relock_fire) begin
            armed_q <= 1'b0;
         end else if (lock_s2_q) begin
            armed_q <= 1'b1;
         end
      end
   end

   // successive approximation search
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q      <= vco_cal_pkg::CAL_IDLE;
         cal_pend_q   <= 1'b0;
         cal_req_q    <= 1'b0;
         sel_q        <= 8'h00;
         bit_idx_q    <= 3'h0;
         wait_q       <= 10'h000;
         win_q        <= 32'h0000_0000;
         meas_q       <= 32'h0000_0000;
         o_vtune_hold <= 1'b0;
         o_cal_busy   <= 1'b0;
      end else begin
         state_q    <= state_d;
         cal_pend_q <= freq_trig || relock_fire || (cal_pend_q && !cal_start);
         o_cal_busy <= (state_d != vco_cal_pkg::CAL_IDLE);
         if (link_start && !host_pend_q) begin
            cal_req_q <= 1'b0;
         end
         unique case (state_q)
            vco_cal_pkg::CAL_IDLE: begin
               if (cal_start) begin
                  sel_q        <= 8'h00;
                  bit_idx_q    <= 3'(vco_cal_pkg::SW_BITS - 1);
                  cal_req_q    <= 1'b1;
                  o_vtune_hold <= 1'b1;
               end
            end
            vco_cal_pkg::CAL_SEND: begin
               wait_q <= vco_cal_pkg::WAIT_UNIT * {8'h00, cal_k};
            end
            vco_cal_pkg::CAL_WAIT: begin
               if (tick && wait_q != 10'h000) begin
                  wait_q <= wait_q - 10'h001;
               end
               win_q  <= win_len;
               meas_q <= 32'h0000_0000;
            end
            vco_cal_pkg::CAL_MEASURE: begin
               win_q <= win_q - 32'h0000_0001;
               if (i_vco_edge) begin
                  meas_q <= meas_q + 32'h0000_0001;
               end
            end
            vco_cal_pkg::CAL_DECIDE: begin
               // more capacitance lowers the frequency: keep the bit unless too slow
               if (meas_q >= expect_cnt) begin
                  sel_q <= trial;
               end
               if (bit_idx_q != 3'h0) begin
                  bit_idx_q <= bit_idx_q - 3'h1;
               end
               cal_req_q <= 1'b1;
            end
            vco_cal_pkg::CAL_FINAL: begin
            end
            vco_cal_pkg::CAL_LOAD: begin
               o_vtune_hold <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   vco_link_serializer u_link (
      .i_ref_clk    (i_ref_clk),
      .i_rst_b      (i_rst_b),
      .i_tick       (tick),
      .i_start      (link_start),
      .i_word       (link_word),
      .o_busy       (link_busy),
      .o_done       (link_done),
      .o_link_clock (o_vco_link_clock),
      .o_link_data  (o_vco_link_data),
      .o_link_sel_b (o_vco_link_sel_b)
   );

endmodule

// *** include/vco_cal_pkg.sv ***
package vco_cal_pkg;

   // register port geometry
   localparam int DW = 24;
   localparam int AW = 5;

   // register offsets
   localparam logic [4:0] REG_REF_DIV   = 5'h02;
   localparam logic [4:0] REG_INT       = 5'h03;
   localparam logic [4:0] REG_FRAC      = 5'h04;
   localparam logic [4:0] REG_FWD       = 5'h05;
   localparam logic [4:0] REG_MODE      = 5'h06;
   localparam logic [4:0] REG_LOCK_CFG  = 5'h07;
   localparam logic [4:0] REG_CAL_CFG   = 5'h0a;
   localparam logic [4:0] REG_READBACK  = 5'h10;

   // field positions
   localparam int MODE_FRAC_BIT   = 11;
   localparam int LOCK_RELOCK_BIT = 13;
   localparam int CAL_DIS_BIT     = 11;
   localparam int CAL_N_LSB       = 0;
   localparam int CAL_K_LSB       = 6;
   localparam int CAL_M_LSB       = 13;
   localparam int RB_BUSY_BIT     = 8;
   localparam int RB_LOCK_BIT     = 9;
   localparam int INT_W           = 19;

   // forwarding word: [2:0] subsystem id, [6:3] vco register, [15:7] data
   localparam int FWD_ID_LSB   = 0;
   localparam int FWD_REG_LSB  = 3;
   localparam int FWD_DATA_LSB = 7;
   localparam int LINK_BITS    = 16;

   // vco subsystem registers
   localparam logic [3:0] VREG_SWITCH = 4'h0;
   localparam logic [3:0] VREG_DIV    = 4'h2;
   localparam logic [3:0] VREG_CFG    = 4'h3;
   localparam int         DIV_GAIN_LSB = 6;
   localparam logic [5:0] DIV_MAX      = 6'h3e;

   // calibration search
   localparam int        SW_BITS   = 5;
   localparam logic [9:0] WAIT_UNIT = 10'h080;

   // values after reset
   localparam logic [23:0] RST_REF_DIV  = 24'h00_0001;
   localparam logic [23:0] RST_INT      = 24'h00_0000;
   localparam logic [23:0] RST_FRAC     = 24'h00_0000;
   localparam logic [23:0] RST_FWD      = 24'h00_0000;
   localparam logic [23:0] RST_MODE     = 24'h00_0000;
   localparam logic [23:0] RST_LOCK_CFG = 24'h00_0000;
   localparam logic [23:0] RST_CAL_CFG  = 24'h00_0000;
   localparam logic [5:0]  RST_DIV      = 6'h01;

   typedef enum logic [2:0] {
      CAL_IDLE    = 3'b000,
      CAL_SEND    = 3'b001,
      CAL_WAIT    = 3'b010,
      CAL_MEASURE = 3'b011,
      CAL_DECIDE  = 3'b100,
      CAL_FINAL   = 3'b101,
      CAL_LOAD    = 3'b110
   } cal_state_e;

endpackage

// *** hdl/vco_link_serializer.sv ***
`timescale 1ns/100ps
module vco_link_serializer (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   // frame request
   input  wire logic        i_tick,
   input  wire logic        i_start,
   input  wire logic [15:0] i_word,
   output logic             o_busy,
   output logic             o_done,
   // serial link
   output logic             o_link_clock,
   output logic             o_link_data,
   output logic             o_link_sel_b
);

   logic [15:0] shift_q;
   logic [3:0]  bit_q;
   logic        phase_q;
   logic        last_bit;

   assign last_bit = (bit_q == 4'(vco_cal_pkg::LINK_BITS - 1));

   // msb first, data changes on the falling link edge
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shift_q      <= 16'h0000;
         bit_q        <= 4'h0;
         phase_q      <= 1'b0;
         o_busy       <= 1'b0;
         o_done       <= 1'b0;
         o_link_clock <= 1'b0;
         o_link_data  <= 1'b0;
         o_link_sel_b <= 1'b1;
      end else begin
         o_done <= 1'b0;
         if (i_start && !o_busy) begin
            shift_q      <= i_word;
            bit_q        <= 4'h0;
            phase_q      <= 1'b0;
            o_busy       <= 1'b1;
            o_link_sel_b <= 1'b0;
            o_link_clock <= 1'b0;
            o_link_data  <= i_word[15];
         end else if (o_busy && i_tick) begin
            phase_q      <= !phase_q;
            o_link_clock <= !phase_q;
            if (phase_q) begin
               if (last_bit) begin
                  o_busy       <= 1'b0;
                  o_done       <= 1'b1;
                  o_link_sel_b <= 1'b1;
               end else begin
                  bit_q       <= bit_q + 4'h1;
                  shift_q     <= {shift_q[14:0], 1'b0};
                  o_link_data <= shift_q[14];
               end
            end
         end
      end
   end

endmodule

// *** bench/vco_sub_model.sv ***
`timescale 1ns/100ps
module vco_sub_model (
   // clock and link
   input  wire logic        i_ref_clk,
   input  wire logic        i_link_clock,
   input  wire logic        i_link_data,
   input  wire logic        i_link_sel_b,
   // vco side
   output logic             o_vco_edge = 1'b0,
   output logic      [15:0] o_word = 16'h0000,
   output logic      [4:0]  o_sw = 5'h00,
   output int               o_bits = 0
);
   logic [15:0] sh = 16'h0000;
   logic [5:0]  acc = 6'h00;
   logic        clk_q = 1'b0;
   logic        sel_q = 1'b1;
   int          n = 0;
   always @(posedge i_ref_clk) begin
      // higher switch code, fewer edges
      {o_vco_edge, acc} <= {1'b0, acc} + 7'h40 - {1'b0, o_sw, 1'b0};
      clk_q <= i_link_clock;
      sel_q <= i_link_sel_b;
      if (i_link_clock && !clk_q && !i_link_sel_b) begin
         sh <= {sh[14:0], i_link_data};
         n <= n + 1;
      end
      if (i_link_sel_b && !sel_q) begin
         o_word <= sh;
         o_bits <= n;
         n <= 0;
         if (sh[6:3] == 4'h0) begin
            o_sw <= sh[11:7];
         end
      end
   end
endmodule

// *** bench/vco_band_automatic_band_calibration_controller_props.sv ***
`timescale 1ns/100ps
module vco_band_automatic_band_calibration_controller_props (
   // clock and reset
   input wire logic        i_ref_clk,
   input wire logic        i_rst_b,
   // register port
   input wire logic [4:0]  i_addr,
   input wire logic [23:0] i_wdata,
   input wire logic        i_wr,
   // loop and link
   input wire logic        i_lock_detect,
   input wire logic        o_vtune_hold,
   input wire logic [18:0] o_int_active,
   input wire logic [23:0] o_frac_active,
   input wire logic        o_cal_busy,
   input wire logic        o_vco_link_clock,
   input wire logic        o_vco_link_data,
   input wire logic        o_vco_link_sel_b,
   input wire logic [5:0]  o_out_div_ratio
);
   logic       cal_dis_q;
   logic       frac_q;
   logic       relock_q;
   logic       clk_q;
   logic [5:0] edges_q;
   wire        wr_frac = i_wr && i_addr == vco_cal_pkg::REG_FRAC;
   wire        wr_int  = i_wr && i_addr == vco_cal_pkg::REG_INT;
   wire        trig    = !cal_dis_q && !o_cal_busy && (frac_q ? wr_frac : wr_int);
   wire        direct  = cal_dis_q && !o_cal_busy;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cal_dis_q <= 1'b0;
         frac_q    <= 1'b0;
         relock_q  <= 1'b0;
         clk_q     <= 1'b0;
         edges_q   <= 6'h00;
      end else begin
         clk_q <= o_vco_link_clock;
         if (i_wr && i_addr == vco_cal_pkg::REG_CAL_CFG) cal_dis_q <= i_wdata[11];
         if (i_wr && i_addr == vco_cal_pkg::REG_MODE) frac_q <= i_wdata[11];
         if (i_wr && i_addr == vco_cal_pkg::REG_LOCK_CFG) relock_q <= i_wdata[13];
         if (o_vco_link_sel_b) edges_q <= 6'h00;
         else if (o_vco_link_clock && !clk_q) edges_q <= edges_q + 6'h01;
      end
   end
   default clocking dclk @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   property p_hold; o_vtune_hold == o_cal_busy; endproperty
   a_hold: assert property (p_hold) else $error("hold outside run");
   property p_start; trig |-> ##[1:3] o_cal_busy; endproperty
   a_start: assert property (p_start) else $error("no run after write");
   property p_wait; trig && wr_frac |=> $stable(o_frac_active) [*8]; endproperty
   a_wait: assert property (p_wait) else $error("frac loaded early");
   property p_int; direct && wr_int |=> o_int_active == $past(i_wdata[18:0]); endproperty
   a_int: assert property (p_int) else $error("int not direct");
   property p_frac; direct && wr_frac |=> o_frac_active == $past(i_wdata); endproperty
   a_frac: assert property (p_frac) else $error("frac not direct");
   property p_bits; $rose(o_vco_link_sel_b) |-> edges_q == 6'h10; endproperty
   a_bits: assert property (p_bits) else $error("frame clock count");
   property p_idle; o_vco_link_sel_b |-> !o_vco_link_clock; endproperty
   a_idle: assert property (p_idle) else $error("link clock outside frame");
   property p_data; $rose(o_vco_link_clock) |-> $stable(o_vco_link_data); endproperty
   a_data: assert property (p_data) else $error("data moved on rise");
   property p_div;
      $changed(o_out_div_ratio) |-> $past(o_vco_link_sel_b) && !$past(o_vco_link_sel_b, 2)
         && (o_out_div_ratio == 6'h01 || !o_out_div_ratio[0]);
   endproperty
   a_div: assert property (p_div) else $error("bad divider update");
   property p_relock;
      relock_q && !cal_dis_q && !o_cal_busy && $fell(i_lock_detect) && $past(i_lock_detect, 4)
         |-> ##[2:8] o_cal_busy;
   endproperty
   a_relock: assert property (p_relock) else $error("no relock");
endmodule
bind vco_band_automatic_band_calibration_controller vco_band_automatic_band_calibration_controller_props u_props (.*);

// *** bench/vco_band_automatic_band_calibration_controller_tb.sv ***
`timescale 1ns/100ps
module vco_band_automatic_band_calibration_controller_tb;
   logic        i_ref_clk = 1'b0;
   logic        i_rst_b = 1'b0;
   logic [4:0]  i_addr = 5'h00;
   logic [23:0] i_wdata = 24'h00_0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_lock_detect = 1'b1;
   logic [23:0] o_rdata, o_frac_active, d;
   logic [18:0] o_int_active;
   logic [5:0]  o_out_div_ratio, rt, er;
   logic [1:0]  o_out_gain;
   logic        o_vtune_hold, o_cal_busy, o_vco_link_clock, o_vco_link_data;
   logic        o_vco_link_sel_b, o_doubler_en, i_vco_edge;
   logic [15:0] m_word;
   logic [4:0]  m_sw, tg, sw;
   logic [31:0] lf = 32'hf902_c4c9;
   int          m_bits, seen, n_errors = 0, n_compared = 0, cyc = 0;
   realtime     t0;
   localparam int dv_tab[4] = '{1, 4, 16, 32};
   always #5 i_ref_clk = ~i_ref_clk;
   vco_band_automatic_band_calibration_controller dut (.*);
   vco_sub_model model (
      .i_ref_clk(i_ref_clk), .i_link_clock(o_vco_link_clock), .i_link_data(o_vco_link_data),
      .i_link_sel_b(o_vco_link_sel_b), .o_vco_edge(i_vco_edge), .o_word(m_word), .o_sw(m_sw),
      .o_bits(m_bits));
   function automatic logic [31:0] nxt(input logic [31:0] l);
      return {l[30:0], 1'b0} ^ ({32{l[31]}} & 32'h0040_0007);
   endfunction
   function automatic logic [4:0] exp_sw(input logic [4:0] t);
      return 5'(6'h20 - {1'b0, t});
   endfunction
   function automatic logic [5:0] exp_div(input logic [5:0] cur, input logic [5:0] r);
      return (r == 6'h01 || !r[0]) ? r : cur;
   endfunction
   task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] v);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic rd(input logic [4:0] a, output logic [23:0] v);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(negedge i_ref_clk);
      v = o_rdata;
      @(posedge i_ref_clk);
   endtask
   task automatic frame();
      wait (o_vco_link_sel_b === 1'b0);
      wait (o_vco_link_sel_b === 1'b1);
      repeat (3) @(posedge i_ref_clk);
   endtask
   task automatic run();
      wait (o_cal_busy === 1'b1);
      wait (o_cal_busy === 1'b0);
      repeat (3) @(posedge i_ref_clk);
   endtask
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         $display("wrong value cycle limit expected done seen hang");
         report_and_stop();
      end
   end
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      chk("div reset", o_out_div_ratio, 24'h00_0001);
      wr(vco_cal_pkg::REG_FWD, 24'h00_0005);
      frame();
      wr(vco_cal_pkg::REG_MODE, 24'h00_0800);
      wr(vco_cal_pkg::REG_CAL_CFG, 24'h00_0045);
      for (int i = 0; i < 4; i++) begin
         if (i != 2) lf = nxt(lf);
         tg = {1'b0, lf[3:0]} + 5'h01;
         wr(vco_cal_pkg::REG_FRAC, {tg, 19'h0_0000});
         run();
         rd(vco_cal_pkg::REG_READBACK, d);
         chk("read-back", d, {14'h0000, 2'b10, 3'h0, exp_sw(tg)});
         chk("switch", m_sw, exp_sw(tg));
         chk("id", m_word[6:0], 7'h05);
         chk("frac", o_frac_active, {tg, 19'h0_0000});
      end
      $display("test automatic_band_calibration done");
      for (int i = 0; i < 4; i++) begin
         lf = nxt(lf);
         sw = lf[4:0];
         wr(vco_cal_pkg::REG_CAL_CFG, {9'h000, i[1:0], 2'b01, 11'h005});
         wr(vco_cal_pkg::REG_FWD, {12'h000, sw, 7'h05});
         @(posedge o_vco_link_clock) t0 = $realtime;
         @(posedge o_vco_link_clock) chk("period", int'(($realtime - t0) / 10), 2 * dv_tab[i]);
         frame();
         chk("switch", m_sw, sw);
         chk("bits", m_bits, 24'h00_0010);
         rd(vco_cal_pkg::REG_READBACK, d);
         chk("read-back", d, {14'h0000, 2'b10, 3'h0, sw});
         wr(vco_cal_pkg::REG_FRAC, lf[23:0]);
         chk("frac", o_frac_active, lf[23:0]);
         wr(vco_cal_pkg::REG_INT, {5'h00, lf[31:13]});
         chk("int", o_int_active, lf[31:13]);
         chk("busy", o_cal_busy, 1'b0);
      end
      wr(vco_cal_pkg::REG_CAL_CFG, 24'h00_0805);
      er = 6'h01;
      for (int j = 0; j < 4; j++) begin
         lf = nxt(lf);
         rt = (j == 0) ? 6'h3e : (j == 1) ? 6'h07 : (j == 2) ? 6'h01 : {1'b0, lf[3:0], 1'b0} + 6'h02;
         er = exp_div(er, rt);
         wr(vco_cal_pkg::REG_FWD, {8'h00, 1'b0, lf[9:8], rt, 4'h2, 3'h5});
         frame();
         chk("ratio", o_out_div_ratio, er);
         chk("gain", o_out_gain, lf[9:8]);
      end
      wr(vco_cal_pkg::REG_FWD, {17'h0_0001, 4'h3, 3'h5});
      frame();
      chk("doubler", o_doubler_en, 1'b1);
      $display("test manual done");
      wr(vco_cal_pkg::REG_CAL_CFG, 24'h00_0045);
      wr(vco_cal_pkg::REG_LOCK_CFG, 24'h00_2000);
      repeat (8) @(posedge i_ref_clk);
      i_lock_detect <= 1'b0;
      run();
      seen = 0;
      repeat (300) begin
         @(negedge i_ref_clk);
         if (o_cal_busy === 1'b1) seen++;
      end
      chk("reruns", seen, 24'h00_0000);
      i_lock_detect <= 1'b1;
      $display("test relock done");
      report_and_stop();
   end
endmodule
